// >>> include/hss_cfg.svh
`ifndef HSS_CFG_SVH
`define HSS_CFG_SVH

// Width of the homing method field; it holds 0 through 10.
`define HSS_METHOD_W 4
// Highest method handled here; higher values are refused with a fault.
`define HSS_METHOD_MAX 4'h7
// First method that searches on the overtravel limits instead of the home switch.
`define HSS_METHOD_LIMIT_BASE 4'h4
// Width of the trajectory step counter.
`define HSS_STEP_W 2
// Trajectory steps.
`define HSS_STEP_FAST 2'h0
`define HSS_STEP_SLOW 2'h1
`define HSS_STEP_EDGE 2'h2
`define HSS_STEP_INDEX 2'h3
// Clock period and the time held at standstill for each stop, in ns.
`define HSS_CLK_PERIOD_NS 100
`define HSS_DECEL_TIME_NS 1000
// Width of the standstill counter.
`define HSS_DECEL_CNT_W 16
// Number of synchronised inputs: home switch, forward limit, reverse limit, index.
`define HSS_NUM_IN 4
`define HSS_IN_HOME 0
`define HSS_IN_FWD 1
`define HSS_IN_REV 2
`define HSS_IN_INDEX 3

`endif

// >>> include/hss_pkg.sv
package hss_pkg;

    // Sequencer states.
    typedef enum logic [2:0] {
        HSS_IDLE,
        HSS_RUN,
        HSS_DECEL,
        HSS_STOP,
        HSS_DONE,
        HSS_FAULT
    } hss_state_t;

    // Motion command handed to the profile generator.
    typedef struct packed {
        logic run;
        logic dir_fwd;
        logic speed_high;
    } hss_motion_t;

endpackage : hss_pkg

// >>> src/hss_homing_sequencer.sv
// What this block does
// - Method 0: fast forward to switch rise, slow reverse to fall, slow forward to rise.
// - Method 0: forward limit first, fast reverse to switch rise, then as usual.
// - Method 0: switch high at start skips fast phase, slow reverse then forward.
// - Method 1: fast reverse to switch rise, slow forward to fall, slow back to rise.
// - Method 1: reverse limit first, fast forward to switch rise, then slow finish.
// - Method 1: switch high at start, slow forward to fall, slow reverse to rise.
// - Method 2: like method 0, then home on first forward index pulse.
// - Method 2: after forward limit, fast reverse path, then forward index home.
// - Method 2: switch high at start, slow reverse, slow forward, index home.
// - Method 3: mirror of method 2, homing on first reverse index pulse.
// - Method 3: reverse limit first, fast forward path, then reverse index home.
// - Method 3: switch high at start, slow forward to fall, reverse, index home.
// - Method 4: fast forward to forward limit rise, slow reverse, home at its fall.
// - Method 4: forward limit high at start, slow reverse only, home at its fall.
// - Method 5: fast reverse to reverse limit rise, slow forward, home at fall.
// - Method 5: reverse limit high at start, slow forward only, home at fall.
// - Method 6: fast forward to limit, slow reverse to limit fall, then index home.
// - Method 6: limit high at start, slow reverse to fall, then index home.
// - Method 7: fast reverse to limit, slow forward to limit fall, then index.
// - Method 7: limit high at start, slow forward to limit fall, then index.
// - Method 6 uses forward limit as slow-down point, index as home.
// - Methods 0-3 slow down at switch; 0,1 home on switch, 2,3 on index.
// - Method field holds 0 to 10; only 0 to 7 are searched here.
// - Done output high only after success; low when absent, aborted or failed.
// - Search fast until first home-related edge, then slow for precision.
`timescale 1ns/1ps

`include "hss_cfg.svh"

module hss_homing_sequencer #(
    parameter int unsigned DECEL_TIME_NS = `HSS_DECEL_TIME_NS,
    parameter int unsigned CLK_PERIOD_NS = `HSS_CLK_PERIOD_NS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start_pulse,
    input wire logic abort_pulse,
    input wire logic [`HSS_METHOD_W-1:0] homing_method_select,
    input wire logic home_switch_input,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic index_pulse_input,
    output hss_pkg::hss_motion_t motion_profile,
    output logic homing_done_output,
    output logic homing_busy,
    output logic homing_fault
);
    import hss_pkg::*;

    // Standstill time rounded up to whole cycles, never below one.
    localparam int unsigned DECEL_CYC_RAW = (DECEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DECEL_CYC = (DECEL_CYC_RAW < 1) ? 1 : DECEL_CYC_RAW;
    localparam logic [`HSS_DECEL_CNT_W-1:0] DECEL_LAST = `HSS_DECEL_CNT_W'(DECEL_CYC - 1);

    // Pin synchronisers and edge history.
    logic [`HSS_NUM_IN-1:0] pin_meta_q;
    logic [`HSS_NUM_IN-1:0] pin_sync_q;
    logic [`HSS_NUM_IN-1:0] pin_prev_q;
    logic [`HSS_NUM_IN-1:0] pin_raw;

    // Sequencer state.
    hss_state_t state_q, state_d;
    logic [`HSS_STEP_W-1:0] step_q, step_d;
    logic [`HSS_METHOD_W-1:0] method_q, method_d;
    logic redir_q, redir_d;
    logic [`HSS_DECEL_CNT_W-1:0] cnt_q, cnt_d;

    // Registered outputs.
    hss_motion_t motion_q, motion_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    logic fault_q, fault_d;

    // Decoded edges and the current trajectory segment.
    logic [`HSS_NUM_IN-1:0] rise;
    logic [`HSS_NUM_IN-1:0] fall;
    logic switch_group;
    logic fwd_first;
    logic lim_rise;
    logic lim_fall;
    logic trav_lim_rise;
    logic seg_fwd;
    logic seg_high;
    logic seg_evt;
    logic seg_home;
    logic seg_cont;
    logic redirect;
    logic start_sw_group;
    logic start_fwd;
    logic start_active;
    logic [`HSS_STEP_W-1:0] start_step;

    assign pin_raw = {index_pulse_input, reverse_limit_input, forward_limit_input,
                      home_switch_input};

    // Every pin crosses two flops first; the third stage only serves edge detection,
    // so a fresh edge is seen two cycles after the pin moves.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Edges are taken from the synchronised copy only.
    always_comb begin
        rise = pin_sync_q & ~pin_prev_q;
        fall = ~pin_sync_q & pin_prev_q;
    end

    // Branch choice at start, made from the live method field and the stable switch levels.
    always_comb begin
        start_sw_group = homing_method_select < `HSS_METHOD_LIMIT_BASE;
        start_fwd = ~homing_method_select[0];
        if (start_sw_group) begin
            start_active = pin_sync_q[`HSS_IN_HOME];
        end else if (start_fwd) begin
            start_active = pin_sync_q[`HSS_IN_FWD];
        end else begin
            start_active = pin_sync_q[`HSS_IN_REV];
        end
        // Already on the slow-down point: skip the fast phase.
        start_step = start_active ? `HSS_STEP_SLOW : `HSS_STEP_FAST;
    end

    // Segment decoder: direction, speed and the edge that ends the running segment.
    always_comb begin
        switch_group = method_q < `HSS_METHOD_LIMIT_BASE;
        fwd_first = ~method_q[0];
        lim_rise = fwd_first ? rise[`HSS_IN_FWD] : rise[`HSS_IN_REV];
        lim_fall = fwd_first ? fall[`HSS_IN_FWD] : fall[`HSS_IN_REV];
        seg_fwd = fwd_first;
        seg_high = 1'b0;
        seg_evt = 1'b0;
        seg_home = 1'b0;
        seg_cont = 1'b0;
        trav_lim_rise = 1'b0;
        if (switch_group) begin
            case (step_q)
                `HSS_STEP_FAST: begin
                    // After hitting the limit the fast search runs the other way.
                    seg_fwd = fwd_first ^ redir_q;
                    seg_high = 1'b1;
                    seg_evt = rise[`HSS_IN_HOME];
                    trav_lim_rise = seg_fwd ? rise[`HSS_IN_FWD] : rise[`HSS_IN_REV];
                end
                `HSS_STEP_SLOW: begin
                    seg_fwd = ~fwd_first;
                    seg_evt = fall[`HSS_IN_HOME];
                end
                `HSS_STEP_EDGE: begin
                    seg_evt = rise[`HSS_IN_HOME];
                    // Methods 0 and 1 home here; 2 and 3 keep creeping to the index.
                    seg_home = ~method_q[1];
                    seg_cont = method_q[1];
                end
                default: begin
                    seg_evt = rise[`HSS_IN_INDEX];
                    seg_home = 1'b1;
                end
            endcase
        end else begin
            case (step_q)
                `HSS_STEP_FAST: begin
                    seg_high = 1'b1;
                    seg_evt = lim_rise;
                end
                `HSS_STEP_SLOW: begin
                    seg_fwd = ~fwd_first;
                    seg_evt = lim_fall;
                    // Methods 4 and 5 home on the limit edge; 6 and 7 go on to the index.
                    seg_home = ~method_q[1];
                    seg_cont = method_q[1];
                end
                default: begin
                    seg_fwd = ~fwd_first;
                    seg_evt = rise[`HSS_IN_INDEX];
                    seg_home = 1'b1;
                end
            endcase
        end
        // A limit met during the first fast search turns the search round once.
        redirect = trav_lim_rise & ~redir_q;
    end

    // Sequencer next state. Abort wins over everything and leaves done low.
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        method_d = method_q;
        redir_d = redir_q;
        cnt_d = cnt_q;
        done_d = done_q;
        fault_d = fault_q;
        if (abort_pulse) begin
            state_d = HSS_IDLE;
            done_d = 1'b0;
            fault_d = 1'b0;
        end else begin
            case (state_q)
                HSS_IDLE, HSS_DONE, HSS_FAULT: begin
                    if (start_pulse) begin
                        done_d = 1'b0;
                        method_d = homing_method_select;
                        redir_d = 1'b0;
                        cnt_d = '0;
                        if (homing_method_select > `HSS_METHOD_MAX) begin
                            // Methods above 7 are not searched here.
                            state_d = HSS_FAULT;
                            fault_d = 1'b1;
                        end else begin
                            state_d = HSS_RUN;
                            fault_d = 1'b0;
                            step_d = start_step;
                        end
                    end
                end
                HSS_RUN: begin
                    if (redirect) begin
                        redir_d = 1'b1;
                        cnt_d = '0;
                        state_d = HSS_DECEL;
                    end else if (seg_evt) begin
                        cnt_d = '0;
                        if (seg_home) begin
                            state_d = HSS_STOP;
                        end else begin
                            step_d = step_q + `HSS_STEP_W'(1);
                            // The index hunt carries on without stopping.
                            state_d = seg_cont ? HSS_RUN : HSS_DECEL;
                        end
                    end
                end
                HSS_DECEL: begin
                    if (cnt_q == DECEL_LAST) begin
                        state_d = HSS_RUN;
                    end else begin
                        cnt_d = cnt_q + `HSS_DECEL_CNT_W'(1);
                    end
                end
                HSS_STOP: begin
                    if (cnt_q == DECEL_LAST) begin
                        state_d = HSS_DONE;
                        done_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + `HSS_DECEL_CNT_W'(1);
                    end
                end
                default: begin
                    state_d = HSS_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= HSS_IDLE;
            step_q <= `HSS_STEP_FAST;
            method_q <= '0;
            redir_q <= 1'b0;
            cnt_q <= '0;
            done_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            method_q <= method_d;
            redir_q <= redir_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            fault_q <= fault_d;
        end
    end

    // Motion command follows the running segment one cycle late; the profile
    // generator ramps anyway, so the extra cycle costs only a few counts.
    always_comb begin
        motion_d = '0;
        busy_d = (state_q == HSS_RUN) || (state_q == HSS_DECEL) || (state_q == HSS_STOP);
        if (state_q == HSS_RUN && !abort_pulse) begin
            motion_d.run = 1'b1;
            motion_d.dir_fwd = seg_fwd;
            motion_d.speed_high = seg_high;
        end
    end

    // Output registers.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            motion_q <= '0;
            busy_q <= 1'b0;
        end else begin
            motion_q <= motion_d;
            busy_q <= busy_d;
        end
    end

    assign motion_profile = motion_q;
    assign homing_done_output = done_q;
    assign homing_busy = busy_q;
    assign homing_fault = fault_q;

endmodule : hss_homing_sequencer

// >>> sim/hss_homing_props_properties.sv
`timescale 1ns/1ps
`include "hss_cfg.svh"
module hss_homing_props #(
    parameter int unsigned DECEL_TIME_NS = 1000,
    parameter int unsigned CLK_PERIOD_NS = 100
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start_pulse,
    input wire logic abort_pulse,
    input wire logic [`HSS_METHOD_W-1:0] homing_method_select,
    input wire logic home_switch_input,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic index_pulse_input,
    input wire hss_pkg::hss_motion_t motion_profile,
    input wire logic homing_done_output,
    input wire logic homing_busy,
    input wire logic homing_fault
);
    import hss_pkg::*;
    localparam int DC = DECEL_TIME_NS / CLK_PERIOD_NS;
    logic [15:0] low_q;
    logic [15:0] low_d;
    logic slow_q;
    logic slow_d;
    logic go;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // A start that the idle sequencer accepts.
    assign go = start_pulse && !abort_pulse && !homing_busy;
    // Standstill length so far, and whether this search has already gone slow.
    always_comb begin
        low_d = motion_profile.run ? 16'h0 : low_q + 16'h1;
        slow_d = homing_busy && (slow_q || (motion_profile.run && !motion_profile.speed_high));
    end
    // Registers only; reset clears both so a fresh search starts clean.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            low_q <= 16'h0;
            slow_q <= 1'b0;
        end else begin
            low_q <= low_d;
            slow_q <= slow_d;
        end
    end
    property p_fault_set; go && homing_method_select > 4'h7 |=> homing_fault; endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("no fault after start with unsupported method");
    property p_launch; go && homing_method_select <= 4'h7 |-> ##2 homing_busy && motion_profile.run;
    endproperty
    a_launch: assert property (p_launch)
        else $error("search did not start two cycles after start");
    property p_abort;
        abort_pulse |=> !homing_done_output && !homing_fault ##1 !homing_busy && !motion_profile.run;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not clear done and motion");
    property p_done;
        $rose(homing_done_output) |-> $past(homing_busy) && !motion_profile.run &&
            !$past(motion_profile.run) ##1 !homing_busy;
    endproperty
    a_done: assert property (p_done)
        else $error("done rose without a stop at the end of a search");
    property p_hold_dir; motion_profile.run && $past(motion_profile.run) |-> $stable(motion_profile.dir_fwd);
    endproperty
    a_hold_dir: assert property (p_hold_dir)
        else $error("direction changed while moving");
    property p_standstill; $rose(motion_profile.run) && $past(homing_busy) |-> low_q >= DC; endproperty
    a_standstill: assert property (p_standstill)
        else $error("motion resumed before the standstill time");
    property p_slow_stays; slow_q && motion_profile.run |-> !motion_profile.speed_high; endproperty
    a_slow_stays: assert property (p_slow_stays)
        else $error("high speed after the slow phase began");
    property p_done_holds; homing_done_output && !start_pulse && !abort_pulse |=> homing_done_output;
    endproperty
    a_done_holds: assert property (p_done_holds)
        else $error("done dropped without start or abort");
    property p_fault_still; homing_fault |-> !motion_profile.run && !homing_done_output; endproperty
    a_fault_still: assert property (p_fault_still)
        else $error("motion or done while faulted");
    c_done: cover property ($rose(homing_done_output));
    c_fault: cover property ($rose(homing_fault));
    c_abort: cover property (abort_pulse && homing_busy);
endmodule : hss_homing_props
bind hss_homing_sequencer hss_homing_props #(
    .DECEL_TIME_NS(DECEL_TIME_NS), .CLK_PERIOD_NS(CLK_PERIOD_NS)
) u_props (
    .mclk, .sys_rst, .start_pulse, .abort_pulse, .homing_method_select, .home_switch_input,
    .forward_limit_input, .reverse_limit_input, .index_pulse_input, .motion_profile,
    .homing_done_output, .homing_busy, .homing_fault
);

// >>> sim/hss_axis_model.sv
`timescale 1ns/1ps
module hss_axis_model #(
    parameter int HS_LO = 200,
    parameter int HS_HI = 260,
    parameter int FWD_LIM = 1000,
    parameter int REV_LIM = -1000,
    parameter int FAST_STEP = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic signed [31:0] load_pos,
    input wire hss_pkg::hss_motion_t motion_profile,
    output logic signed [31:0] pos_q,
    output logic home_switch_input,
    output logic forward_limit_input,
    output logic reverse_limit_input,
    output logic index_pulse_input
);
    import hss_pkg::*;
    logic signed [31:0] pos_d;
    // Integrate the commanded motion; the axis keeps coasting for as long as run is held.
    always_comb begin
        pos_d = pos_q;
        if (load) begin
            pos_d = load_pos;
        end else if (motion_profile.run) begin
            pos_d = pos_q + (motion_profile.dir_fwd ? 1 : -1) * (motion_profile.speed_high ? FAST_STEP : 1);
        end
    end
    // Position register.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_q <= 32'sh0;
        end else begin
            pos_q <= pos_d;
        end
    end
    // Cams and mark follow the position, so every edge appears where the axis really is.
    assign home_switch_input = (pos_q >= HS_LO) && (pos_q <= HS_HI);
    assign forward_limit_input = pos_q >= FWD_LIM;
    assign reverse_limit_input = pos_q <= REV_LIM;
    // Mark is four counts wide; at high speed it can be crossed in one cycle.
    assign index_pulse_input = pos_q[5:0] < 6'h4;
endmodule : hss_axis_model

// >>> sim/homing_search_sequencer_tb.sv
`timescale 1ns/1ps
`include "hss_cfg.svh"
module homing_search_sequencer_tb;
    import hss_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic start_pulse = 1'b0;
    logic abort_pulse = 1'b0;
    logic [`HSS_METHOD_W-1:0] homing_method_select = 4'h0;
    logic load = 1'b0;
    logic signed [31:0] load_pos = 32'sh0;
    logic signed [31:0] pos_q;
    logic home_switch_input;
    logic forward_limit_input;
    logic reverse_limit_input;
    logic index_pulse_input;
    hss_motion_t motion_profile;
    logic homing_done_output;
    logic homing_busy;
    logic homing_fault;
    int errors = 0;
    int checks = 0;
    // Clock of 100 ns period.
    always #50 mclk = ~mclk;
    hss_homing_sequencer dut_u (
        .mclk, .sys_rst, .start_pulse, .abort_pulse, .homing_method_select, .home_switch_input,
        .forward_limit_input, .reverse_limit_input, .index_pulse_input, .motion_profile,
        .homing_done_output, .homing_busy, .homing_fault
    );
    hss_axis_model u_axis (
        .mclk, .sys_rst, .load, .load_pos, .motion_profile, .pos_q, .home_switch_input,
        .forward_limit_input, .reverse_limit_input, .index_pulse_input
    );
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // Pulse start at a clock edge, together with the method field.
    task automatic kick(input logic [3:0] m);
        @(posedge mclk);
        homing_method_select <= m;
        start_pulse <= 1'b1;
        @(posedge mclk);
        start_pulse <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : kick
    // Place the axis, run one method, judge the first segment and where it stops.
    task automatic home_run(input logic [3:0] m, input int p0, input int ex, input logic fwd,
        input logic skip);
        int d;
        int n;
        @(posedge mclk);
        load <= 1'b1;
        load_pos <= p0;
        @(posedge mclk);
        load <= 1'b0;
        repeat (4) @(posedge mclk);
        kick(m);
        chk("run", 32'h1, 32'(motion_profile.run));
        chk("speed_high", 32'(!skip), 32'(motion_profile.speed_high));
        chk("dir_fwd", 32'(skip ^ !m[0]), 32'(motion_profile.dir_fwd));
        n = 0;
        while (homing_done_output !== 1'b1 && homing_fault !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("done", 32'h1, 32'(homing_done_output));
        chk("run at end", 32'h0, 32'(motion_profile.run));
        d = fwd ? pos_q - ex : ex - pos_q;
        chk("stop position near home", 32'h1, 32'(d >= 0 && d <= 12));
        $display("method %0d from %0d stopped at %0d", m, p0, pos_q);
    endtask : home_run
    // Methods 0 and 1 stop on the switch edge; a far start, a limit start, a start on the cam.
    task automatic t_switch_home();
        home_run(4'h0, 0, 200, 1'b1, 1'b0);
        home_run(4'h0, 500, 200, 1'b1, 1'b0);
        home_run(4'h0, 230, 200, 1'b1, 1'b1);
        home_run(4'h1, 600, 260, 1'b0, 1'b0);
        home_run(4'h1, -500, 260, 1'b0, 1'b0);
        home_run(4'h1, 230, 260, 1'b0, 1'b1);
        $display("switch home test ended");
    endtask : t_switch_home
    // Methods 2 and 3 stop on the first mark past the switch edge.
    // In reverse, the mark just inside the cam top comes right after the switch edge.
    task automatic t_index_home();
        home_run(4'h2, 0, 256, 1'b1, 1'b0);
        home_run(4'h2, 500, 256, 1'b1, 1'b0);
        home_run(4'h2, 230, 256, 1'b1, 1'b1);
        home_run(4'h3, 600, 259, 1'b0, 1'b0);
        home_run(4'h3, -500, 259, 1'b0, 1'b0);
        home_run(4'h3, 230, 259, 1'b0, 1'b1);
        $display("index home test ended");
    endtask : t_index_home
    // Methods 4 to 7 use the limits; starting inside a limit skips the fast phase.
    task automatic t_limit_home();
        home_run(4'h4, 0, 999, 1'b0, 1'b0);
        home_run(4'h4, 1005, 999, 1'b0, 1'b1);
        home_run(4'h5, 0, -999, 1'b1, 1'b0);
        home_run(4'h5, -1005, -999, 1'b1, 1'b1);
        home_run(4'h6, 0, 963, 1'b0, 1'b0);
        home_run(4'h6, 1005, 963, 1'b0, 1'b1);
        home_run(4'h7, 0, -960, 1'b1, 1'b0);
        home_run(4'h7, -1005, -960, 1'b1, 1'b1);
        $display("limit home test ended");
    endtask : t_limit_home
    // Abort in mid-search must stop the axis and leave done low.
    task automatic t_abort();
        kick(4'h0);
        repeat (3) @(posedge mclk);
        abort_pulse <= 1'b1;
        @(posedge mclk);
        abort_pulse <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("busy after abort", 32'h0, 32'(homing_busy));
        chk("run after abort", 32'h0, 32'(motion_profile.run));
        chk("done after abort", 32'h0, 32'(homing_done_output));
        repeat (12) @(posedge mclk);
        $display("abort test ended");
    endtask : t_abort
    // Methods 8 to 10 are refused with a fault and no motion.
    task automatic t_bad_method();
        for (int m = 8; m <= 10; m++) begin
            kick(4'(m));
            chk("fault", 32'h1, 32'(homing_fault));
            chk("done", 32'h0, 32'(homing_done_output));
            chk("run", 32'h0, 32'(motion_profile.run));
        end
        $display("method refusal test ended");
    endtask : t_bad_method
    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_switch_home();
        t_index_home();
        t_limit_home();
        t_abort();
        t_bad_method();
        close_out();
    end
    // Watchdog sized well above the longest expected run.
    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        close_out();
    end
endmodule : homing_search_sequencer_tb
